// ===== hdl/dac_fmt_pkg.sv
// constants, field positions and reset values of the input format bank
// How it works
// [RL1] Offset correction runs only while format bit 15 is set.
// [RL2] Both converters run while bit 14 is set; it resets to the fuse value.
// [RL3] Bits 13:12 set width: 00 all 14 bits, 01 upper 12, 10 and 11 upper 10.
// [RL4] Bit 11 reverses input bits: each 7-bit half, or the whole 14-bit word.
// [RL5] Bit 10 picks two's-complement (1) or offset binary (0); resets to 1.
// [RL6] Bit 9 selects the four-pin serial port; die-id enable overrides it.
// [RL7] The format word is at address zero, all read/write, reset to 0x44FC with bit 14 taken from the fuse.
// [RL8] Input bits below the selected width are ignored and taken as zero.
`default_nettype none
package dac_fmt_pkg;
  localparam logic [6:0]  ADDR_FORMAT = 7'h00;
  localparam logic [6:0]  ADDR_PAT6   = 7'h12;
  localparam logic [6:0]  ADDR_PAT7   = 7'h13;
  localparam logic [6:0]  ADDR_DIRECT = 7'h14;
  localparam logic [6:0]  ADDR_SLEEP  = 7'h15;
  localparam logic [6:0]  ADDR_DATA0  = 7'h16;
  localparam logic [6:0]  ADDR_DATA1  = 7'h17;
  localparam logic [6:0]  ADDR_DATA2  = 7'h18;
  localparam logic [6:0]  ADDR_DATA3  = 7'h19;
  localparam logic [6:0]  ADDR_ID     = 7'h7F;
  localparam logic [15:0] RST_FORMAT  = 16'h44FC;
  localparam logic [15:0] RST_PAT6    = 16'h1515;
  localparam logic [15:0] RST_PAT7    = 16'h3ABA;
  localparam logic [15:0] RST_DIRECT  = 16'h0000;
  localparam logic [15:0] RST_SLEEP   = 16'hFFFF;
  localparam logic [15:0] RST_DATA    = 16'h0000;
  localparam int          BIT_OFS_EN  = 15;
  localparam int          BIT_DUAL    = 14;
  localparam int          BIT_WID_HI  = 13;
  localparam int          BIT_WID_LO  = 12;
  localparam int          BIT_REV     = 11;
  localparam int          BIT_TWOS    = 10;
  localparam int          BIT_FOUR    = 9;
  localparam int          BIT_DIR_EN  = 15;
  localparam int          SAMPLE_W    = 14;
  localparam logic [1:0]  WIDTH_14    = 2'h0;
  localparam logic [1:0]  WIDTH_12    = 2'h1;
  localparam logic [13:0] MASK_14     = 14'h3FFF;
  localparam logic [13:0] MASK_12     = 14'h3FFC;
  localparam logic [13:0] MASK_10     = 14'h3FF0;
  localparam logic [13:0] MID_SCALE   = 14'h2000;
  localparam logic [14:0] SAT_MAX     = 15'h1FFF;
  localparam logic [14:0] SAT_MIN     = 15'h6000;
  localparam logic [4:0]  HEAD_BITS   = 5'h08;
  localparam logic [4:0]  FRAME_BITS  = 5'h18;
  // identification fields; values are arbitrary
  localparam logic [1:0]  MAKER_CODE  = 2'h2;
  localparam logic [2:0]  VERSION_ID  = 3'h5;
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_HEAD = 2'b01,
    SP_DATA = 2'b10,
    SP_DONE = 2'b11
  } sp_state_t;
endpackage
`default_nettype wire

// ===== hdl/cfg_bus_if.sv
// register access path between the serial port and the register bank
`default_nettype none
interface cfg_bus_if;
  logic        wr;
  logic [6:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport port (output wr, output addr, output wdata, input rdata);
  modport bank (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== hdl/serial_cfg_port.sv
// serial configuration port slave: 1 r/w bit, 7 address bits, 16 data bits
`default_nettype none
module serial_cfg_port
  import dac_fmt_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sclk,
  input  wire logic sen_n,
  input  wire logic sdio_in,
  input  wire logic four_pin,
  cfg_bus_if.port   bus,
  output var  logic sdio_out,
  output var  logic sdio_oe,
  output var  logic sdo_out,
  output var  logic sdo_oe
);
  sp_state_t   state_reg;
  logic        sclk_reg;
  logic [4:0]  cnt_reg;
  logic [15:0] in_reg;
  logic [15:0] out_reg;
  logic        bit_reg;
  logic        rw_reg;
  logic [6:0]  addr_reg;
  logic        wr_reg;
  logic        drive_reg;
  logic        rise;
  logic        fall;

  // sclk is a plain synchronous input, edges found against last sample
  assign rise = sclk & ~sclk_reg;
  assign fall = ~sclk & sclk_reg;
  always_ff @(posedge clk) begin
    sclk_reg <= rst ? 1'b0 : sclk;
  end

  // frame sequencing; a high enable aborts the frame at once
  always_ff @(posedge clk) begin
    wr_reg <= 1'b0;
    if (rst || sen_n) begin
      state_reg <= SP_IDLE;
      cnt_reg   <= 5'h00;
    end else begin
      if (state_reg == SP_IDLE) begin
        state_reg <= SP_HEAD;
      end
      if (rise && state_reg != SP_DONE) begin
        in_reg  <= {in_reg[14:0], sdio_in};
        cnt_reg <= cnt_reg + 5'h01;
        if (cnt_reg == HEAD_BITS - 5'h01) begin
          rw_reg    <= in_reg[6];
          addr_reg  <= {in_reg[5:0], sdio_in};
          state_reg <= SP_DATA;
        end
        if (cnt_reg == FRAME_BITS - 5'h01) begin
          wr_reg    <= ~rw_reg;
          state_reg <= SP_DONE;
        end
      end
    end
  end

  // read data leaves on falling edges so the host samples on rising
  always_ff @(posedge clk) begin
    if (rst || sen_n) begin
      bit_reg   <= 1'b0;
      drive_reg <= 1'b0;
      out_reg   <= 16'h0000;
    end else if (fall && state_reg == SP_DATA && rw_reg) begin
      drive_reg <= 1'b1;
      if (cnt_reg == HEAD_BITS) begin
        bit_reg <= bus.rdata[15];
        out_reg <= {bus.rdata[14:0], 1'b0};
      end else begin
        bit_reg <= out_reg[15];
        out_reg <= {out_reg[14:0], 1'b0};
      end
    end
  end

  assign bus.wr    = wr_reg;
  assign bus.addr  = addr_reg;
  assign bus.wdata = in_reg;
  // three-pin turns sdio around; four-pin answers on its own pin
  assign sdio_out  = bit_reg;
  assign sdo_out   = bit_reg;
  assign sdio_oe   = drive_reg & ~four_pin; // RL6
  assign sdo_oe    = drive_reg & four_pin;  // RL6
endmodule
`default_nettype wire

// ===== hdl/sample_formatter.sv
// one channel: reversal, width mask, coding and offset correction
`default_nettype none
module sample_formatter
  import dac_fmt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [13:0] raw,
  input  wire logic        full_word,
  input  wire logic [1:0]  width,
  input  wire logic        rev,
  input  wire logic        twos,
  input  wire logic        ofs_en,
  input  wire logic [12:0] ofs,
  input  wire logic        direct_en,
  input  wire logic [13:0] direct,
  input  wire logic        enable,
  output var  logic [13:0] code
);
  logic [13:0] rev_whole;
  logic [13:0] rev_half;
  logic [13:0] picked;
  logic [13:0] masked;
  logic [13:0] signed_in;
  logic [14:0] sum;
  logic [14:0] sat;

  // bit reversal, whole word or each seven-bit half
  for (genvar i = 0; i < SAMPLE_W; i++) begin : g_rev
    assign rev_whole[i] = raw[SAMPLE_W - 1 - i];
    assign rev_half[i]  = raw[(i < 7) ? (6 - i) : (20 - i)];
  end
  assign picked = !rev ? raw : (full_word ? rev_whole : rev_half); // RL4

  // low bits outside the chosen width read as zero
  always_comb begin
    case (width)
      WIDTH_14: masked = picked & MASK_14; // RL3
      WIDTH_12: masked = picked & MASK_12; // RL3
      default:  masked = picked & MASK_10; // RL3 RL8
    endcase
  end

  // work in two's complement; offset binary only needs its msb flipped
  assign signed_in = twos ? masked : {~masked[13], masked[12:0]}; // RL5
  assign sum = {signed_in[13], signed_in}
             + (ofs_en ? {{2{ofs[12]}}, ofs} : 15'h0000); // RL1
  // saturate rather than wrap, a wrap would flip full scale
  always_comb begin
    if (!sum[14] && sum[13]) begin
      sat = SAT_MAX;
    end else if (sum[14] && !sum[13]) begin
      sat = SAT_MIN;
    end else begin
      sat = sum;
    end
  end

  // the converter takes offset binary; idle channel parks at mid scale
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      code <= MID_SCALE; // RL2
    end else if (direct_en) begin
      code <= direct;
    end else begin
      code <= {~sat[13], sat[12:0]};
    end
  end
endmodule
`default_nettype wire

// ===== hdl/dac_input_format_config.sv
// input format register bank with serial access and two channel formatters
`default_nettype none
module dac_input_format_config
  import dac_fmt_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        SCLK,
  input  wire logic        SEN_N,
  input  wire logic        SDIO_IN,
  output var  logic        SDIO_OUT,
  output var  logic        SDIO_OE,
  output var  logic        SDO_OUT,
  output var  logic        SDO_OE,
  input  wire logic        DIE_ID_ENABLE,
  input  wire logic        DUAL_FUSE,
  input  wire logic        FULL_WORD,
  input  wire logic [13:0] SAMPLE_A,
  input  wire logic [13:0] SAMPLE_B,
  input  wire logic [12:0] OFFSET_A,
  input  wire logic [12:0] OFFSET_B,
  input  wire logic [63:0] CAPTURE_DATA,
  output var  logic [13:0] CODE_A,
  output var  logic [13:0] CODE_B,
  output var  logic [15:0] FORMAT_CONTROL,
  output var  logic        FOUR_PIN_ACTIVE,
  output var  logic [13:0] TEST_PATTERN_SIX,
  output var  logic [13:0] TEST_PATTERN_SEVEN,
  output var  logic [15:0] SLEEP_CONTROL
);
  cfg_bus_if   bus ();
  logic [15:0] format_reg;
  logic [13:0] pat6_reg;
  logic [13:0] pat7_reg;
  logic        direct_en_reg;
  logic [13:0] direct_reg;
  logic [15:0] sleep_reg;
  logic [63:0] data_reg;
  logic [15:0] id_word;
  logic        four_pin;
  logic        offset_en;
  logic        dual_en;
  logic [1:0]  width_sel;
  logic        reverse;
  logic        twos_in;

  // die-id enable outranks the four-pin request
  assign four_pin = format_reg[BIT_FOUR] & ~DIE_ID_ENABLE; // RL6

  serial_cfg_port u_port (
    .clk      (CLK),
    .rst      (SYS_RST),
    .sclk     (SCLK),
    .sen_n    (SEN_N),
    .sdio_in  (SDIO_IN),
    .four_pin (four_pin),
    .bus      (bus.port),
    .sdio_out (SDIO_OUT),
    .sdio_oe  (SDIO_OE),
    .sdo_out  (SDO_OUT),
    .sdo_oe   (SDO_OE)
  );

  // format word: every bit writable; dual bit starts from the fuse
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      format_reg           <= RST_FORMAT; // RL7
      format_reg[BIT_DUAL] <= DUAL_FUSE;  // RL2
    end else if (bus.wr && bus.addr == ADDR_FORMAT) begin
      format_reg <= bus.wdata; // RL7
    end
  end

  // test pattern words keep 14 bits, upper bits read zero
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pat6_reg <= RST_PAT6[13:0];
      pat7_reg <= RST_PAT7[13:0];
    end else if (bus.wr) begin
      if (bus.addr == ADDR_PAT6) begin
        pat6_reg <= bus.wdata[13:0];
      end
      if (bus.addr == ADDR_PAT7) begin
        pat7_reg <= bus.wdata[13:0];
      end
    end
  end

  // direct converter value overrides the sample path when enabled
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      direct_en_reg <= RST_DIRECT[BIT_DIR_EN];
      direct_reg    <= RST_DIRECT[13:0];
    end else if (bus.wr && bus.addr == ADDR_DIRECT) begin
      direct_en_reg <= bus.wdata[BIT_DIR_EN];
      direct_reg    <= bus.wdata[13:0];
    end
  end

  // sleep control word is passed straight out to the power logic
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sleep_reg <= RST_SLEEP;
    end else if (bus.wr && bus.addr == ADDR_SLEEP) begin
      sleep_reg <= bus.wdata;
    end
  end

  // read-only data words; sampled every cycle, host writes ignored
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      data_reg <= {4{RST_DATA}};
    end else begin
      data_reg <= CAPTURE_DATA;
    end
  end

  assign id_word = {11'h000, MAKER_CODE, VERSION_ID};

  // read mux; unmapped addresses return zero
  always_comb begin
    case (bus.addr)
      ADDR_FORMAT: bus.rdata = format_reg; // RL7
      ADDR_PAT6:   bus.rdata = {2'h0, pat6_reg};
      ADDR_PAT7:   bus.rdata = {2'h0, pat7_reg};
      ADDR_DIRECT: bus.rdata = {direct_en_reg, 1'b0, direct_reg};
      ADDR_SLEEP:  bus.rdata = sleep_reg;
      ADDR_DATA0:  bus.rdata = data_reg[15:0];
      ADDR_DATA1:  bus.rdata = data_reg[31:16];
      ADDR_DATA2:  bus.rdata = data_reg[47:32];
      ADDR_DATA3:  bus.rdata = data_reg[63:48];
      ADDR_ID:     bus.rdata = id_word;
      default:     bus.rdata = 16'h0000;
    endcase
  end

  // decoded controls for the sample path
  assign offset_en = format_reg[BIT_OFS_EN]; // RL1
  assign dual_en   = format_reg[BIT_DUAL];   // RL2
  assign width_sel = format_reg[BIT_WID_HI:BIT_WID_LO]; // RL3
  assign reverse   = format_reg[BIT_REV];    // RL4
  assign twos_in   = format_reg[BIT_TWOS];   // RL5

  // channel a always runs; channel b idles unless both are in use
  sample_formatter u_fmt_a (
    .clk       (CLK),
    .rst       (SYS_RST),
    .raw       (SAMPLE_A),
    .full_word (FULL_WORD),
    .width     (width_sel),
    .rev       (reverse),
    .twos      (twos_in),
    .ofs_en    (offset_en),
    .ofs       (OFFSET_A),
    .direct_en (direct_en_reg),
    .direct    (direct_reg),
    .enable    (1'b1),
    .code      (CODE_A)
  );

  sample_formatter u_fmt_b (
    .clk       (CLK),
    .rst       (SYS_RST),
    .raw       (SAMPLE_B),
    .full_word (FULL_WORD),
    .width     (width_sel),
    .rev       (reverse),
    .twos      (twos_in),
    .ofs_en    (offset_en),
    .ofs       (OFFSET_B),
    .direct_en (direct_en_reg),
    .direct    (direct_reg),
    .enable    (dual_en), // RL2
    .code      (CODE_B)
  );

  // register contents exported to the rest of the converter
  assign FORMAT_CONTROL     = format_reg;
  assign FOUR_PIN_ACTIVE    = four_pin;
  assign TEST_PATTERN_SIX   = pat6_reg;
  assign TEST_PATTERN_SEVEN = pat7_reg;
  assign SLEEP_CONTROL      = sleep_reg;
endmodule
`default_nettype wire

// ===== testbench/dac_fmt_properties.sv
// port checker for the input format bank
`default_nettype none
module dac_fmt_properties
  import dac_fmt_pkg::*;
(
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        DIE_ID_ENABLE,
  input wire logic        DUAL_FUSE,
  input wire logic        FULL_WORD,
  input wire logic [13:0] SAMPLE_A,
  input wire logic [12:0] OFFSET_A,
  input wire logic [13:0] CODE_A,
  input wire logic [13:0] CODE_B,
  input wire logic [15:0] FORMAT_CONTROL,
  input wire logic        FOUR_PIN_ACTIVE
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] f;
  logic [13:0] rv;
  logic [14:0] sm;
  logic [13:0] sat;
  logic        plain;
  // whole-word reversal and clipped sum, both in two's form
  always_comb begin
    for (int i = 0; i < 14; i++) rv[i] = SAMPLE_A[13 - i];
    sm  = {SAMPLE_A[13], SAMPLE_A} + {{2{OFFSET_A[12]}}, OFFSET_A};
    sat = sm[13:0];
    if (sm[14:13] == 2'b01) sat = 14'h1FFF;
    if (sm[14:13] == 2'b10) sat = 14'h2000;
  end
  // plain path: no offset, full width, no reversal
  assign f     = FORMAT_CONTROL;
  assign plain = !f[15] && f[13:11] == 3'h0;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_rst_val;
    $fell(SYS_RST) |-> f == {RST_FORMAT[15], DUAL_FUSE, RST_FORMAT[13:0]};
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("format reset value wrong");
  property p_four;
    FOUR_PIN_ACTIVE == (f[9] && !DIE_ID_ENABLE);
  endproperty
  a_four: assert property (p_four)
    else $error("four-pin select wrong");
  property p_dual;
    !f[14] |=> CODE_B == MID_SCALE;
  endproperty
  a_dual: assert property (p_dual)
    else $error("second channel not idle");
  property p_twos;
    plain && f[10] |=> CODE_A == ($past(SAMPLE_A) ^ MID_SCALE);
  endproperty
  a_twos: assert property (p_twos)
    else $error("two's input coding wrong");
  property p_offbin;
    plain && !f[10] |=> CODE_A == $past(SAMPLE_A);
  endproperty
  a_offbin: assert property (p_offbin)
    else $error("offset binary coding wrong");
  property p_w10;
    !f[15] && f[13] && !f[11] && f[10]
      |=> CODE_A == (($past(SAMPLE_A) & MASK_10) ^ MID_SCALE);
  endproperty
  a_w10: assert property (p_w10)
    else $error("ten-bit width wrong");
  property p_rev;
    !f[15] && f[13:10] == 4'h3 && FULL_WORD
      |=> CODE_A == ($past(rv) ^ MID_SCALE);
  endproperty
  a_rev: assert property (p_rev)
    else $error("word reversal wrong");
  property p_ofs;
    f[15] && f[13:10] == 4'h1 |=> CODE_A == ($past(sat) ^ MID_SCALE);
  endproperty
  a_ofs: assert property (p_ofs)
    else $error("offset correction wrong");
endmodule
bind dac_input_format_config dac_fmt_properties i_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .DIE_ID_ENABLE(DIE_ID_ENABLE),
  .DUAL_FUSE(DUAL_FUSE), .FULL_WORD(FULL_WORD), .SAMPLE_A(SAMPLE_A),
  .OFFSET_A(OFFSET_A), .CODE_A(CODE_A), .CODE_B(CODE_B),
  .FORMAT_CONTROL(FORMAT_CONTROL), .FOUR_PIN_ACTIVE(FOUR_PIN_ACTIVE));
`default_nettype wire

// ===== testbench/cfg_host.sv
// host model driving the serial configuration port
`default_nettype none
module cfg_host (
  input  wire logic clk,
  input  wire logic sdio,
  input  wire logic sdo,
  input  wire logic four,
  output var  logic sclk,
  output var  logic sen_n,
  output var  logic dout,
  output var  logic rel
);
  timeunit 1ns;
  timeprecision 100ps;
  // serial clock stands low and the frame is closed between frames
  initial begin
    sclk  = 1'b0;
    sen_n = 1'b1;
    dout  = 1'b0;
    rel   = 1'b0;
  end
  // one 24-bit frame; each serial phase lasts three system clocks
  task automatic xfer(input logic [23:0] w, output logic [15:0] q);
    q = 16'h0000;
    @(posedge clk);
    sen_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      rel  <= w[23] && i < 16;
      dout <= w[i];
      repeat (3) @(posedge clk);
      sclk <= 1'b1;
      if (i < 16) q[i] = four ? sdo : sdio;
      repeat (3) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (3) @(posedge clk);
    sen_n <= 1'b1;
    rel   <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the input format bank
`default_nettype none
module tb_top
  import dac_fmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [54:0] REGS [9] = '{
    {7'h00, 16'hFFFF, 16'h44FC, 16'hFFFF},
    {7'h12, 16'hFFFF, 16'h1515, 16'h3FFF},
    {7'h13, 16'h1234, 16'h3ABA, 16'h1234},
    {7'h14, 16'h4ABC, 16'h0000, 16'h0ABC},
    {7'h15, 16'h0F0F, 16'hFFFF, 16'h0F0F},
    {7'h16, 16'hFFFF, 16'h1111, 16'h1111},
    {7'h19, 16'hFFFF, 16'h4444, 16'h4444},
    {7'h20, 16'hFFFF, 16'h0000, 16'h0000},
    {7'h7F, 16'hFFFF, 16'h0015, 16'h0015}};
  localparam logic [43:0] SMP [10] = '{
    {16'h4400, 1'b1, 14'h3FFF, 13'h0000},
    {16'h0000, 1'b1, 14'h1555, 13'h0000},
    {16'h5400, 1'b1, 14'h2ABF, 13'h0000},
    {16'h6400, 1'b1, 14'h2ABF, 13'h0000},
    {16'h7400, 1'b1, 14'h1ABF, 13'h0000},
    {16'h4C00, 1'b1, 14'h0123, 13'h0000},
    {16'h4C00, 1'b0, 14'h0123, 13'h0000},
    {16'hC400, 1'b1, 14'h1F00, 13'h0FFF},
    {16'hC400, 1'b1, 14'h2100, 13'h1000},
    {16'h4400, 1'b1, 14'h1F00, 13'h0FFF}};
  logic        clk, sclk, sen_n, dout, rel, sdio, sdo, four;
  logic        sdio_o, sdio_e, sdo_o, sdo_e;
  logic        rst = 1'b1;
  logic        tog = 1'b0;
  logic        die = 1'b0;
  logic        fuse = 1'b1;
  logic        fw = 1'b1;
  logic [13:0] sa = 14'h0000;
  logic [13:0] sb = 14'h0000;
  logic [12:0] oa = 13'h0000;
  logic [63:0] cap = 64'h4444_3333_2222_1111;
  logic [13:0] ca, cb, p6, p7;
  logic [15:0] fc, slp, q;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  // released lines show a changing pattern, not the last value
  assign sdio = sdio_e ? sdio_o : (rel ? tog : dout);
  assign sdo  = sdo_e ? sdo_o : tog;
  dac_input_format_config i_dut (
    .CLK(clk), .SYS_RST(rst), .SCLK(sclk), .SEN_N(sen_n), .SDIO_IN(sdio),
    .SDIO_OUT(sdio_o), .SDIO_OE(sdio_e), .SDO_OUT(sdo_o), .SDO_OE(sdo_e),
    .DIE_ID_ENABLE(die), .DUAL_FUSE(fuse), .FULL_WORD(fw),
    .SAMPLE_A(sa), .SAMPLE_B(sb), .OFFSET_A(oa), .OFFSET_B(oa),
    .CAPTURE_DATA(cap), .CODE_A(ca), .CODE_B(cb), .FORMAT_CONTROL(fc),
    .FOUR_PIN_ACTIVE(four), .TEST_PATTERN_SIX(p6),
    .TEST_PATTERN_SEVEN(p7), .SLEEP_CONTROL(slp));
  cfg_host i_host (.clk(clk), .sdio(sdio), .sdo(sdo), .four(four),
    .sclk(sclk), .sen_n(sen_n), .dout(dout), .rel(rel));
  // clock at 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // expected code: reverse, mask, to two's, offset and clip, to binary
  function automatic logic [13:0] exp_code(logic [15:0] f, logic w,
                                          logic [13:0] s, logic [12:0] o);
    logic [13:0] r;
    logic [14:0] t;
    r = s;
    for (int i = 0; i < 14; i++)
      if (f[11]) r[i] = w ? s[13 - i] : s[i < 7 ? 6 - i : 20 - i];
    r = r & (f[13] ? MASK_10 : f[12] ? MASK_12 : MASK_14);
    if (!f[10]) r = r ^ MID_SCALE;
    t = {r[13], r};
    if (f[15]) t = t + {{2{o[12]}}, o};
    if (t[14:13] == 2'b01) t = 15'h1FFF;
    if (t[14:13] == 2'b10) t = 15'h6000;
    return t[13:0] ^ MID_SCALE;
  endfunction
  // toggle pattern and hang limit, well above the expected 6700 cycles
  always @(posedge clk) begin
    tog <= ~tog;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    logic [43:0] r;
    logic [13:0] ea, eb;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // register rows: reset value, write, read back
    foreach (REGS[i]) begin
      i_host.xfer({1'b1, REGS[i][54:48], 16'h0000}, q);
      chk(q, REGS[i][31:16]);
      i_host.xfer({1'b0, REGS[i][54:32]}, q);
      i_host.xfer({1'b1, REGS[i][54:48], 16'h0000}, q);
      chk(q, REGS[i][15:0]);
    end
    chk({2'h0, p6}, 16'h3FFF);
    chk({2'h0, p7}, 16'h1234);
    chk(slp, 16'h0F0F);
    // sample rows: program the format word, then check both codes
    foreach (SMP[i]) begin
      r = SMP[i];
      i_host.xfer({8'h00, r[43:28]}, q);
      fw <= r[27];
      sa <= r[26:13];
      sb <= ~r[26:13];
      oa <= r[12:0];
      repeat (2) @(posedge clk);
      ea = exp_code(r[43:28], r[27], r[26:13], r[12:0]);
      eb = r[42] ? exp_code(r[43:28], r[27], ~r[26:13], r[12:0]) : MID_SCALE;
      chk({2'h0, ca}, {2'h0, ea});
      chk({2'h0, cb}, {2'h0, eb});
    end
    // direct value overrides channel a; idle channel b stays at mid scale
    i_host.xfer({8'h00, 16'h8000}, q);
    i_host.xfer({8'h14, 16'h8ABC}, q);
    chk({2'h0, ca}, 16'h0ABC);
    chk({2'h0, cb}, {2'h0, MID_SCALE});
    i_host.xfer({8'h14, 16'h0000}, q);
    // four-pin read-back, then die-id forces three pins again
    i_host.xfer({8'h00, 16'h0200}, q);
    chk({15'h0, four}, 16'h0001);
    i_host.xfer({8'h80, 16'h0000}, q);
    chk(q, 16'h0200);
    die <= 1'b1;
    i_host.xfer({8'h80, 16'h0000}, q);
    chk(q, 16'h0200);
    chk({15'h0, four}, 16'h0000);
    // second reset with the fuse cleared
    fuse <= 1'b0;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    // values held while reset is still applied
    chk({2'h0, ca}, {2'h0, MID_SCALE});
    chk({2'h0, cb}, {2'h0, MID_SCALE});
    chk({2'h0, p6}, RST_PAT6);
    chk(slp, RST_SLEEP);
    rst <= 1'b0;
    i_host.xfer({8'h80, 16'h0000}, q);
    chk(q, 16'h04FC);
    chk(fc, 16'h04FC);
    print_verdict();
  end
endmodule
`default_nettype wire
